// ---- design/dual_watchdog_system.sv ----
// dual watchdog system: windowed watchdog plus independent watchdog
// Overview of operation
// - two separate watchdogs, each resets device alone
// - enable by startup option strap or software
// - once active, only device reset disables
// - window watchdog resets on expiry, 75us-64ms
// - refresh above window compare value resets device
// - independent watchdog counts low speed oscillator
// - independent watchdog survives cpu clock failure
//
// assumes software strobes come from logic on clk; straps, the cpu clock
// good flag and the oscillator are asynchronous pins
`timescale 1ns/1ps
`include "wdg_defines.svh"

module dual_watchdog_system #(
    parameter int WWDG_CNT_W   = `WWDG_CNT_W,
    parameter int IWDG_CNT_W   = `IWDG_CNT_W,
    parameter int STEP_CYCLES  = `WWDG_STEP_CPU_CYCLES,
    parameter int IWDG_PRESCALE = `IWDG_PRESCALE
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  wwdg_opt_en,
    input  wire logic                  iwdg_opt_en,
    input  wire logic                  wwdg_sw_enable,
    input  wire logic                  iwdg_sw_enable,
    input  wire logic                  wwdg_refresh,
    input  wire logic [WWDG_CNT_W-1:0] wwdg_load_value,
    input  wire logic [WWDG_CNT_W-1:0] wwdg_window_value,
    input  wire logic                  iwdg_reload,
    input  wire logic [IWDG_CNT_W-1:0] iwdg_reload_value,
    input  wire logic                  low_speed_internal_osc,
    input  wire logic                  cpu_clk_ok,
    output logic                       wwdg_active,
    output logic                       iwdg_active,
    output logic      [WWDG_CNT_W-1:0] wwdg_count,
    output logic                       wwdg_reset,
    output logic                       iwdg_reset,
    output logic                       device_reset
);
    import wdg_pkg::*;

    // ==========================================================
    // declarations
    // ==========================================================
    logic [1:0]              wopt_sync_reg;   // window strap synchroniser
    logic [1:0]              iopt_sync_reg;   // independent strap synchroniser
    logic [1:0]              cpu_ok_sync_reg; // cpu clock good synchroniser
    logic [2:0]              osc_sync_reg;    // oscillator sync plus edge history
    logic [1:0]              strap_wait_reg;  // cycles since reset release
    logic                    strap_done_reg;  // straps already sampled
    logic                    strap_take;      // the one sampling cycle
    logic [6:0]              cpu_acc_reg;     // fractional cpu rate divider
    logic [7:0]              cpu_acc_sum;     // accumulator sum before wrap
    logic                    cpu_tick;        // one 16 MHz cpu cycle
    logic [`WWDG_STEP_W-1:0] step_reg;        // cpu cycles within a step
    logic                    step_tick;       // one countdown step
    logic                    osc_tick;        // rising oscillator edge
    wdg_state_type           wwdg_state_reg;  // window watchdog state
    logic                    wwdg_fire;       // window watchdog fires now
    logic [WWDG_CNT_W-1:0]   load_clamped;    // load bounded to timeout range
    logic                    iwdg_expired;    // counter reached terminal value
    logic [IWDG_CNT_W-1:0]   iwdg_count_w;    // independent count (unused out)

    // clamp a requested load so the timeout stays within the longest one
    function automatic logic [WWDG_CNT_W-1:0] clamp_load(
        input logic [WWDG_CNT_W-1:0] value
    );
        logic [WWDG_CNT_W-1:0] top;
        top = WWDG_CNT_W'(`WWDG_STEPS_MAX - 1);
        clamp_load = (value > top) ? top : value;
    endfunction

    assign load_clamped = clamp_load(wwdg_load_value);

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // two flops on every asynchronous pin; the oscillator keeps a third
    // stage so its edge detector never looks at the first flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wopt_sync_reg   <= 2'h0;
            iopt_sync_reg   <= 2'h0;
            cpu_ok_sync_reg <= 2'h0;
            osc_sync_reg    <= 3'h0;
        end else begin
            wopt_sync_reg   <= {wopt_sync_reg[0], wwdg_opt_en};
            iopt_sync_reg   <= {iopt_sync_reg[0], iwdg_opt_en};
            cpu_ok_sync_reg <= {cpu_ok_sync_reg[0], cpu_clk_ok};
            osc_sync_reg    <= {osc_sync_reg[1:0], low_speed_internal_osc};
        end
    end

    // one tick per rising oscillator edge, on block clk, not cpu clock
    assign osc_tick = osc_sync_reg[1] && !osc_sync_reg[2];

    // ==========================================================
    // startup strap sampling
    // ==========================================================
    // straps are read once, after the synchronisers have filled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_wait_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            if (strap_take) begin
                strap_done_reg <= 1'b1;
            end else begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
        end
    end

    assign strap_take = !strap_done_reg && (strap_wait_reg == 2'(`STRAP_WAIT_CYCLES - 1));

    // ==========================================================
    // cpu rate divider
    // ==========================================================
    // 16 of every 125 block cycles carry a cpu tick; ticks stop while the
    // cpu clock is reported bad, which stalls only the window watchdog
    assign cpu_acc_sum = {1'b0, cpu_acc_reg} + 8'(`CPU_FREQ_MHZ);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_acc_reg <= 7'h0;
            cpu_tick    <= 1'b0;
        end else if (cpu_acc_sum >= 8'(`CLK_FREQ_MHZ)) begin
            cpu_acc_reg <= 7'(cpu_acc_sum - 8'(`CLK_FREQ_MHZ));
            cpu_tick    <= cpu_ok_sync_reg[1];
        end else begin
            cpu_acc_reg <= cpu_acc_sum[6:0];
            cpu_tick    <= 1'b0;
        end
    end

    // ==========================================================
    // window watchdog step prescaler
    // ==========================================================
    // one step is the shortest timeout; restarted by each refresh
    assign step_tick = cpu_tick && (step_reg == `WWDG_STEP_W'(STEP_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_reg <= '0;
        end else if (wwdg_state_reg != WDG_RUN || wwdg_refresh) begin
            step_reg <= '0;
        end else if (cpu_tick) begin
            step_reg <= step_tick ? '0 : step_reg + 1'b1;
        end
    end

    // ==========================================================
    // window watchdog state and counter
    // ==========================================================
    // fire on a refresh above the window, or on a step at zero
    always_comb begin
        wwdg_fire = 1'b0;
        if (wwdg_state_reg == WDG_RUN) begin
            if (wwdg_refresh) begin
                wwdg_fire = (wwdg_count > wwdg_window_value);
            end else if (step_tick) begin
                wwdg_fire = (wwdg_count == '0);
            end
        end
    end

    // no path leads back to idle except the asynchronous reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wwdg_state_reg <= WDG_IDLE;
            wwdg_count     <= '0;
        end else begin
            unique case (wwdg_state_reg)
                WDG_IDLE: begin
                    // strap at startup or software command starts it
                    if ((strap_take && wopt_sync_reg[1]) || wwdg_sw_enable) begin
                        wwdg_state_reg <= WDG_RUN;
                        wwdg_count     <= load_clamped;
                    end
                end
                WDG_RUN: begin
                    if (wwdg_fire) begin
                        wwdg_state_reg <= WDG_FIRED;
                    end else if (wwdg_refresh) begin
                        // in-window refresh reloads the count       
                        wwdg_count <= load_clamped;
                    end else if (step_tick) begin
                        wwdg_count <= wwdg_count - 1'b1;
                    end
                end
                WDG_FIRED: begin
                    // holds until the device reset clears everything
                    wwdg_state_reg <= WDG_FIRED;
                end
            endcase
        end
    end

    // ==========================================================
    // independent watchdog activation
    // ==========================================================
    // latches on strap or software; nothing but reset clears it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            iwdg_active <= 1'b0;
        end else if ((strap_take && iopt_sync_reg[1]) || iwdg_sw_enable) begin
            iwdg_active <= 1'b1;
        end
    end

    // window watchdog activity is registered from its state or a start request, so it rises with the state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wwdg_active <= 1'b0;
        end else begin
            wwdg_active <= (wwdg_state_reg != WDG_IDLE) || wwdg_sw_enable
                           || (strap_take && wopt_sync_reg[1]);
        end
    end

    // ==========================================================
    // independent watchdog counter
    // ==========================================================
    // runs on oscillator ticks only, so a dead cpu clock cannot stop it
    iwdg_counter #(
        .CNT_W    (IWDG_CNT_W),
        .PRE_W    (`IWDG_PRE_W),
        .PRESCALE (IWDG_PRESCALE)
    ) u_iwdg (
        .clk          (clk),
        .rst_b        (rst_b),
        .tick         (osc_tick),
        .enable       (iwdg_active),
        .reload       (iwdg_reload),
        .reload_value (iwdg_reload_value),
        .expired      (iwdg_expired),
        .count        (iwdg_count_w)
    );

    // ==========================================================
    // reset requests
    // ==========================================================
    // each source sets its own sticky flag; either one resets the device
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wwdg_reset   <= 1'b0;
            iwdg_reset   <= 1'b0;
            device_reset <= 1'b0;
        end else begin
            wwdg_reset   <= wwdg_reset | wwdg_fire;
            iwdg_reset   <= iwdg_reset | iwdg_expired;
            device_reset <= device_reset | wwdg_fire | iwdg_expired;
        end
    end

endmodule

// ---- design/iwdg_counter.sv ----
// independent watchdog down counter, advanced by low speed oscillator ticks
// assumes tick is a one-cycle enable already synchronised to clk
`timescale 1ns/1ps
`include "wdg_defines.svh"

module iwdg_counter #(
    parameter int CNT_W    = `IWDG_CNT_W,
    parameter int PRE_W    = `IWDG_PRE_W,
    parameter int PRESCALE = `IWDG_PRESCALE
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic             reload,
    input  wire logic [CNT_W-1:0] reload_value,
    output logic                  expired,
    output logic      [CNT_W-1:0] count
);
    import wdg_pkg::*;

    logic [PRE_W-1:0] pre_reg;       // prescaler over oscillator ticks
    logic             started_reg;   // first load done after enable
    logic             pre_tick;      // one prescaled count step

    assign pre_tick = tick && (pre_reg == PRE_W'(PRESCALE - 1));

    // ==========================================================
    // prescaler
    // ==========================================================
    // divides the oscillator ticks; a reload also restarts it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= '0;
        end else if (!enable || reload) begin
            pre_reg <= '0;
        end else if (tick) begin
            pre_reg <= pre_tick ? '0 : pre_reg + 1'b1;
        end
    end

    // ==========================================================
    // down counter and expiry
    // ==========================================================
    // loads on enable and on every reload while enabled and not expired, fires at zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count       <= '0;
            started_reg <= 1'b0;
            expired     <= 1'b0;
        end else if (enable && !expired) begin
            if (!started_reg || reload) begin
                // first load or software reload restarts the count
                count       <= reload_value;
                started_reg <= 1'b1;
            end else if (pre_tick) begin
                if (count == '0) begin
                    expired <= 1'b1;
                end else begin
                    count <= count - 1'b1;
                end
            end
        end
    end

endmodule

// ---- design/wdg_defines.svh ----
// timing and sizing constants for the dual watchdog system
// assumes a 125 MHz block clock and a 16 MHz nominal cpu clock rate
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH

// ==========================================================
// clock rates
// ==========================================================
`define CLK_FREQ_MHZ          125
`define CPU_FREQ_MHZ          16

// ==========================================================
// windowed watchdog timing
// ==========================================================
`define WWDG_MIN_TIMEOUT_NS   75000
`define WWDG_MAX_TIMEOUT_NS   64000000
// cpu cycles in one countdown step (75 us at 16 MHz, rounded up)
`define WWDG_STEP_CPU_CYCLES  ((`WWDG_MIN_TIMEOUT_NS * `CPU_FREQ_MHZ + 999) / 1000)
// number of steps that fit in the longest timeout (rounded down)
`define WWDG_STEPS_MAX        (`WWDG_MAX_TIMEOUT_NS / `WWDG_MIN_TIMEOUT_NS)
`define WWDG_CNT_W            10
`define WWDG_STEP_W           11

// ==========================================================
// independent watchdog sizing
// ==========================================================
`define LSI_FREQ_KHZ          128
`define IWDG_CNT_W            12
`define IWDG_PRESCALE         4
`define IWDG_PRE_W            8

// ==========================================================
// startup strap capture delay (cycles after reset release)
// ==========================================================
`define STRAP_WAIT_CYCLES     3

`endif

// ---- design/wdg_pkg.sv ----
// types shared by the dual watchdog system
// assumes nothing of its surroundings
package wdg_pkg;

    // life cycle of one watchdog: off, counting, reset issued
    typedef enum logic [1:0] {
        WDG_IDLE,
        WDG_RUN,
        WDG_FIRED
    } wdg_state_type;

endpackage

// ---- testbench/dual_watchdog_system_bench.sv ----
// self-checking bench for the dual watchdog system
// assumes the design and checker files are compiled before this one
`timescale 1ns/1ps

module dual_watchdog_system_bench;
    // ==========================================================
    // stimulus signals
    // ==========================================================
    localparam int STEP = 2;              // cpu ticks per step, shortened
    localparam int HALF = 488;            // clk cycles in half an oscillator period
    logic        clk = 1'b0;              // block clock
    logic        rst_b = 1'b0;            // active low reset
    logic        wwdg_opt_en = 1'b0;      // window strap
    logic        iwdg_opt_en = 1'b0;      // independent strap
    logic        wwdg_sw_enable = 1'b0;   // window start pulse
    logic        iwdg_sw_enable = 1'b0;   // independent start pulse
    logic        wwdg_refresh = 1'b0;     // window refresh pulse
    logic [9:0]  wwdg_load_value = 'h0;   // window load steps
    logic [9:0]  wwdg_window_value = 'h0; // window compare
    logic        iwdg_reload = 1'b0;      // independent reload pulse
    logic [11:0] iwdg_reload_value = 'h0; // independent load value
    logic        osc = 1'b0;              // low speed oscillator
    logic        cpu_clk_ok = 1'b1;       // cpu clock good
    logic        wwdg_active, iwdg_active, wwdg_reset, iwdg_reset, device_reset;
    logic [9:0]  wwdg_count;              // window counter seen
    int          err_total = 0;           // mismatches
    int          n_checks = 0;            // comparisons

    dual_watchdog_system #(.STEP_CYCLES(STEP), .IWDG_PRESCALE(1)) uut (
        .clk(clk), .rst_b(rst_b), .wwdg_opt_en(wwdg_opt_en), .iwdg_opt_en(iwdg_opt_en),
        .wwdg_sw_enable(wwdg_sw_enable), .iwdg_sw_enable(iwdg_sw_enable),
        .wwdg_refresh(wwdg_refresh), .wwdg_load_value(wwdg_load_value),
        .wwdg_window_value(wwdg_window_value), .iwdg_reload(iwdg_reload),
        .iwdg_reload_value(iwdg_reload_value), .low_speed_internal_osc(osc),
        .cpu_clk_ok(cpu_clk_ok), .wwdg_active(wwdg_active), .iwdg_active(iwdg_active),
        .wwdg_count(wwdg_count), .wwdg_reset(wwdg_reset), .iwdg_reset(iwdg_reset),
        .device_reset(device_reset));

    // ==========================================================
    // shared tasks
    // ==========================================================
    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // hold reset six cycles then release just after an edge
    task automatic do_reset();
        #1 rst_b = 1'b0;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
    endtask

    // one-cycle pulse: 0 wwdg enable, 1 iwdg enable, 2 refresh, 3 reload
    task automatic pulse(input int which);
        @(posedge clk);
        #1;
        case (which)
            0: wwdg_sw_enable = 1'b1;
            1: iwdg_sw_enable = 1'b1;
            2: wwdg_refresh = 1'b1;
            default: iwdg_reload = 1'b1;
        endcase
        @(posedge clk);
        #1;
        {wwdg_sw_enable, iwdg_sw_enable, wwdg_refresh, iwdg_reload} = 4'h0;
    endtask

    // whole oscillator periods, rising edge mid-period
    task automatic osc_ticks(input int n);
        repeat (n) begin
            repeat (HALF) @(posedge clk);
            #1 osc = 1'b1;
            repeat (HALF) @(posedge clk);
            #1 osc = 1'b0;
        end
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    // outputs clear out of reset, nothing starts on its own
    task automatic t_idle();
        do_reset();
        check(device_reset, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        check({wwdg_active, iwdg_active, wwdg_reset}, 3'h0);
    endtask

    // software start, timeout length, second start refused
    task automatic t_timeout();
        int n;
        do_reset();
        wwdg_load_value = 'h2;
        pulse(0);
        check({wwdg_active, wwdg_count}, {1'b1, 10'h2});
        wwdg_load_value = 'h7;
        pulse(0);
        check(wwdg_active && wwdg_count <= 'h2, 1'b1);
        n = 4;
        while (wwdg_reset !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        check(n >= 2 * STEP * 125 / 16 && n <= 4 * STEP * 125 / 16 + 4, 1'b1);
        check(device_reset, 1'b1);
    endtask

    // refresh inside and before the window
    task automatic t_window();
        int n;
        do_reset();
        wwdg_load_value = 'h14;
        wwdg_window_value = 'ha;
        pulse(0);
        n = 0;
        while (wwdg_count > 'ha && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        pulse(2);
        check({wwdg_reset, wwdg_count}, {1'b0, 10'h14});
        pulse(2);
        check({wwdg_reset, device_reset}, 2'h3);
    endtask

    // cpu clock lost: window frozen, independent keeps counting; reload restarts
    task automatic t_independent();
        do_reset();
        iwdg_reload_value = 'h3;
        wwdg_load_value = 'h2;
        cpu_clk_ok = 1'b0;
        pulse(1);
        check(iwdg_active, 1'b1);
        pulse(0);
        osc_ticks(2);
        pulse(3);
        osc_ticks(3);
        check({iwdg_reset, wwdg_reset}, 2'h0);
        check(wwdg_count, 10'h2);
        osc_ticks(1);
        check({iwdg_reset, device_reset}, 2'h3);
        cpu_clk_ok = 1'b1;
    endtask

    // straps start both at startup
    task automatic t_straps();
        wwdg_opt_en = 1'b1;
        iwdg_opt_en = 1'b1;
        wwdg_load_value = 'h5;
        do_reset();
        repeat (8) @(posedge clk);
        #1;
        check({wwdg_active, iwdg_active}, 2'h3);
        wwdg_opt_en = 1'b0;
        iwdg_opt_en = 1'b0;
        pulse(1);
        check({wwdg_active, iwdg_active}, 2'h3);
    endtask

    // ==========================================================
    // run control
    // ==========================================================
    task automatic end_sim();
        $display("checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        t_idle();
        t_timeout();
        t_window();
        t_independent();
        t_straps();
        end_sim();
    end

    // hang guard, well past the expected 50 us of traffic
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule

bind dual_watchdog_system dual_watchdog_system_chk #(
    .WWDG_CNT_W(WWDG_CNT_W), .IWDG_CNT_W(IWDG_CNT_W)) chk_i (
    .clk(clk), .rst_b(rst_b), .wwdg_sw_enable(wwdg_sw_enable),
    .iwdg_sw_enable(iwdg_sw_enable), .wwdg_refresh(wwdg_refresh),
    .wwdg_load_value(wwdg_load_value), .wwdg_window_value(wwdg_window_value),
    .wwdg_active(wwdg_active), .iwdg_active(iwdg_active), .wwdg_count(wwdg_count),
    .wwdg_reset(wwdg_reset), .iwdg_reset(iwdg_reset), .device_reset(device_reset));

// ---- testbench/dual_watchdog_system_chk.sv ----
// port-level checks for the dual watchdog system
// assumes binding onto dual_watchdog_system, single clk domain
`timescale 1ns/1ps
`include "wdg_defines.svh"

module dual_watchdog_system_chk #(
    parameter int WWDG_CNT_W = 10,
    parameter int IWDG_CNT_W = 12
) (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  wwdg_sw_enable,
    input wire logic                  iwdg_sw_enable,
    input wire logic                  wwdg_refresh,
    input wire logic [WWDG_CNT_W-1:0] wwdg_load_value,
    input wire logic [WWDG_CNT_W-1:0] wwdg_window_value,
    input wire logic                  wwdg_active,
    input wire logic                  iwdg_active,
    input wire logic [WWDG_CNT_W-1:0] wwdg_count,
    input wire logic                  wwdg_reset,
    input wire logic                  iwdg_reset,
    input wire logic                  device_reset
);
    // ==========================================================
    // helper logic
    // ==========================================================
    // largest loadable step count, one below the steps in the longest timeout
    localparam logic [WWDG_CNT_W-1:0] LOAD_MAX = WWDG_CNT_W'(`WWDG_STEPS_MAX - 1);
    logic [WWDG_CNT_W-1:0] load_clamped;                // load value after clamping
    logic                  wwdg_run;                    // window watchdog counting
    assign load_clamped = (wwdg_load_value > LOAD_MAX) ? LOAD_MAX : wwdg_load_value;
    assign wwdg_run     = wwdg_active && !wwdg_reset;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // assertions
    // ==========================================================
    a_wwdg_stays_on: assert property (wwdg_active |=> wwdg_active)
        else $error("window watchdog turned off without reset");
    a_iwdg_stays_on: assert property (iwdg_active |=> iwdg_active)
        else $error("independent watchdog turned off without reset");
    a_wwdg_sw_start: assert property (!wwdg_active && wwdg_sw_enable
        |=> wwdg_active && wwdg_count == $past(load_clamped))
        else $error("window watchdog start or load wrong");
    a_iwdg_sw_start: assert property (!iwdg_active && iwdg_sw_enable |=> iwdg_active)
        else $error("independent watchdog did not start");
    a_early_refresh: assert property (wwdg_run && wwdg_refresh
        && wwdg_count > wwdg_window_value |=> wwdg_reset && device_reset)
        else $error("early refresh did not reset");
    a_window_refresh: assert property (wwdg_run && wwdg_refresh
        && wwdg_count <= wwdg_window_value |=> !wwdg_reset && wwdg_count == $past(load_clamped))
        else $error("in-window refresh mishandled");
    a_timeout_zero: assert property ($rose(wwdg_reset) && !$past(wwdg_refresh)
        |-> $past(wwdg_count) == 'h0)
        else $error("window watchdog fired with count not zero");
    a_count_steps: assert property (wwdg_run && !wwdg_refresh && wwdg_count != 'h0
        |=> wwdg_count == $past(wwdg_count) || wwdg_count == $past(wwdg_count) - 1'b1)
        else $error("window counter jumped");
    a_reset_or: assert property (device_reset == (wwdg_reset || iwdg_reset))
        else $error("device reset not the or of both sources");
    a_flags_sticky: assert property ((wwdg_reset || iwdg_reset)
        |=> (wwdg_reset || !$past(wwdg_reset)) && (iwdg_reset || !$past(iwdg_reset)))
        else $error("reset flag cleared without reset");
    a_iwdg_fire_on: assert property (iwdg_reset |-> iwdg_active)
        else $error("independent reset while inactive");
endmodule
